// file: src/gpusb_led.sv
// Traffic indicator for one message stream, active low
`timescale 1ns/10ps
module gpusb_led #(
  parameter int SHORT_CYC = gpusb_pkg::PULSE_SHORT_CYC,
  parameter int LONG_CYC = gpusb_pkg::PULSE_LONG_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire gpusb_pkg::gpusb_led_mode_e mode,
  input wire logic msg,
  output logic led_n
);

  typedef struct packed {
    logic [gpusb_pkg::CNT_W-1:0] cnt;
    logic lvl;
  } gpusb_led_s;

  // Counter width as a plain constant so the load casts stay simple
  localparam int CW = gpusb_pkg::CNT_W;

  gpusb_led_s st;
  gpusb_led_s next_st;

  // ----------------------------------------------------------------
  // Pulse timer and toggle level
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 1'b1;
    end
    if (msg) begin
      case (mode)
        gpusb_pkg::gpusb_led_toggle: next_st.lvl = ~st.lvl;
        // Retrigger restarts the full period
        gpusb_pkg::gpusb_led_slow: next_st.cnt = CW'(LONG_CYC);
        gpusb_pkg::gpusb_led_fast: next_st.cnt = CW'(SHORT_CYC);
        default: next_st.cnt = '0;
      endcase
    end
    if (mode == gpusb_pkg::gpusb_led_off) begin
      next_st.cnt = '0;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '{cnt: '0, lvl: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  // Idle high, low while pulsing; toggle mode shows the level
  always_comb begin
    if (mode == gpusb_pkg::gpusb_led_toggle) begin
      led_n = st.lvl;
    end else begin
      led_n = (st.cnt == '0);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Pulse modes pull the pin low on the edge after any message
  property p_pulse_low;
    @(posedge ref_clk) disable iff (!nrst)
      (msg && (mode == gpusb_pkg::gpusb_led_fast || mode == gpusb_pkg::gpusb_led_slow)) |=> !led_n;
  endproperty
  a_pulse_low: assert property (p_pulse_low) else $error("indicator not low after message");

  // Toggle mode flips the level once per message
  property p_toggle;
    @(posedge ref_clk) disable iff (!nrst)
      (msg && mode == gpusb_pkg::gpusb_led_toggle) ##1 (mode == gpusb_pkg::gpusb_led_toggle)
      |-> led_n != $past(led_n);
  endproperty
  a_toggle: assert property (p_toggle) else $error("indicator did not toggle");
  c_toggle: cover property (@(posedge ref_clk) msg && mode == gpusb_pkg::gpusb_led_toggle);

endmodule : gpusb_led

// file: src/gpusb_pkg.sv
// Package with constants and types for the GPIO and USB status pin block
package gpusb_pkg;

  // ----------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------
  localparam int PORT_W = 8;
  localparam int BIT_SUSPEND = 0;
  localparam int BIT_CFG = 1;
  localparam int BIT_IN_LED = 6;
  localparam int BIT_OUT_LED = 7;

  // ----------------------------------------------------------------
  // Timing at the 125 MHz reference clock
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int PULSE_SHORT_MS = 100;
  localparam int PULSE_LONG_MS = 200;
  localparam int PULSE_SHORT_CYC = (CLK_HZ / 1000) * PULSE_SHORT_MS;
  localparam int PULSE_LONG_CYC = (CLK_HZ / 1000) * PULSE_LONG_MS;
  localparam int RST_FILT_NS = 100;
  localparam int CLK_PERIOD_NS = 8;
  localparam int RST_FILT_CYC = (RST_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CYC = 16;
  localparam int CNT_W = 25;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] DEF_RST = 8'h00;

  // Indicator behaviour selection
  typedef enum logic [1:0] {
    gpusb_led_off,
    gpusb_led_toggle,
    gpusb_led_slow,
    gpusb_led_fast
  } gpusb_led_mode_e;

endpackage : gpusb_pkg

// file: src/gpusb_port.sv
// Eight-bit port with suspend, configuration and traffic status functions
`timescale 1ns/10ps
module gpusb_port #(
  parameter int SHORT_CYC = gpusb_pkg::PULSE_SHORT_CYC,
  parameter int LONG_CYC = gpusb_pkg::PULSE_LONG_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ext_rst_n,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_dir,
  input wire logic [7:0] cfg_default,
  input wire logic cfg_suspend_en,
  input wire logic cfg_done_en,
  input wire gpusb_pkg::gpusb_led_mode_e cfg_in_led_mode,
  input wire gpusb_pkg::gpusb_led_mode_e cfg_out_led_mode,
  input wire logic [7:0] gp_out,
  input wire logic gp_out_wr,
  input wire logic usb_suspend,
  input wire logic usb_resume,
  input wire logic usb_bus_reset,
  input wire logic usb_configured,
  input wire logic usb_in_msg,
  input wire logic usb_out_msg,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] port_value,
  output logic suspended,
  output logic block_rst_n
);

  typedef struct packed {
    logic [1:0] rsync;
    logic [7:0] filt;
    logic [4:0] por;
    logic rst_n;
    logic [7:0] psync1;
    logic [7:0] psync2;
  } gpusb_front_s;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] outv;
    logic sus_en;
    logic cfgd_en;
    gpusb_pkg::gpusb_led_mode_e in_mode;
    gpusb_pkg::gpusb_led_mode_e out_mode;
    logic sus;
    logic cfgd;
    logic [7:0] val;
    logic [7:0] pout;
    logic [7:0] poe;
  } gpusb_core_s;

  gpusb_front_s fr;
  gpusb_front_s next_fr;
  gpusb_core_s st;
  gpusb_core_s next_st;
  logic in_led_n;
  logic out_led_n;

  // ----------------------------------------------------------------
  // Reset filter and power-on reset
  // ----------------------------------------------------------------
  // Power-on reset lands on nrst; the counter stretches it after release
  always_comb begin
    next_fr = fr;
    next_fr.rsync = {fr.rsync[0], ext_rst_n};
    next_fr.psync1 = pin_in;
    next_fr.psync2 = fr.psync1;
    if (fr.rsync[1]) begin
      next_fr.filt = 8'h00;
    end else if (fr.filt != 8'(gpusb_pkg::RST_FILT_CYC)) begin
      next_fr.filt = fr.filt + 8'h01;
    end
    if (fr.por != 5'(gpusb_pkg::POR_CYC)) begin
      next_fr.por = fr.por + 5'h01;
    end
    next_fr.rst_n = (fr.por == 5'(gpusb_pkg::POR_CYC)) && (fr.filt != 8'(gpusb_pkg::RST_FILT_CYC));
  end

  // Front registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fr <= '{rsync: 2'h3, filt: 8'h00, por: 5'h00, rst_n: 1'b0, psync1: 8'h00, psync2: 8'h00};
    end else begin
      fr <= next_fr;
    end
  end

  assign block_rst_n = fr.rst_n;

  // ----------------------------------------------------------------
  // Traffic indicators
  // ----------------------------------------------------------------
  gpusb_led #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_in_led (
    .ref_clk(ref_clk),
    .nrst(fr.rst_n),
    .mode(st.in_mode),
    .msg(usb_in_msg),
    .led_n(in_led_n)
  );

  gpusb_led #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_out_led (
    .ref_clk(ref_clk),
    .nrst(fr.rst_n),
    .mode(st.out_mode),
    .msg(usb_out_msg),
    .led_n(out_led_n)
  );

  // ----------------------------------------------------------------
  // Configuration, USB state and pin muxing
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (cfg_wr) begin
      next_st.dir = cfg_dir;
      next_st.outv = cfg_default;
      next_st.sus_en = cfg_suspend_en;
      next_st.cfgd_en = cfg_done_en;
      next_st.in_mode = cfg_in_led_mode;
      next_st.out_mode = cfg_out_led_mode;
    end else if (gp_out_wr) begin
      next_st.outv = gp_out;
    end
    // Leaving suspend wins so a wake is never lost
    if (usb_resume || usb_bus_reset) begin
      next_st.sus = 1'b0;
    end else if (usb_suspend) begin
      next_st.sus = 1'b1;
    end
    if (usb_bus_reset) begin
      next_st.cfgd = 1'b0;
    end else if (usb_configured) begin
      next_st.cfgd = 1'b1;
    end
    next_st.val = fr.psync2;
    // Plain port first, then the status overrides
    for (int i = 0; i < gpusb_pkg::PORT_W; i++) begin
      next_st.poe[i] = ~next_st.dir[i];
      next_st.pout[i] = next_st.outv[i];
    end
    if (next_st.sus_en) begin
      next_st.poe[gpusb_pkg::BIT_SUSPEND] = 1'b1;
      next_st.pout[gpusb_pkg::BIT_SUSPEND] = ~next_st.sus;
    end
    if (next_st.cfgd_en) begin
      next_st.poe[gpusb_pkg::BIT_CFG] = 1'b1;
      next_st.pout[gpusb_pkg::BIT_CFG] = next_st.cfgd & ~next_st.sus;
    end
    if (st.in_mode != gpusb_pkg::gpusb_led_off) begin
      next_st.poe[gpusb_pkg::BIT_IN_LED] = 1'b1;
      next_st.pout[gpusb_pkg::BIT_IN_LED] = in_led_n;
    end
    if (st.out_mode != gpusb_pkg::gpusb_led_off) begin
      next_st.poe[gpusb_pkg::BIT_OUT_LED] = 1'b1;
      next_st.pout[gpusb_pkg::BIT_OUT_LED] = out_led_n;
    end
  end

  // Core registers, held in reset by the filtered reset
  always_ff @(posedge ref_clk or negedge fr.rst_n) begin
    if (!fr.rst_n) begin
      st <= '{dir: gpusb_pkg::DIR_RST, outv: gpusb_pkg::DEF_RST, sus_en: 1'b0, cfgd_en: 1'b0,
              in_mode: gpusb_pkg::gpusb_led_off, out_mode: gpusb_pkg::gpusb_led_off,
              sus: 1'b0, cfgd: 1'b0, val: 8'h00, pout: 8'h00, poe: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign pin_out = st.pout;
  assign pin_oe = st.poe;
  assign port_value = st.val;
  assign suspended = st.sus;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_sus_pin;
    @(posedge ref_clk) disable iff (!fr.rst_n)
      (st.sus_en && usb_suspend && !usb_resume && !usb_bus_reset && !cfg_wr) |=> (pin_oe[0] && !pin_out[0]);
  endproperty
  a_sus_pin: assert property (p_sus_pin) else $error("suspend pin not low");

  property p_cfg_low_sus;
    @(posedge ref_clk) disable iff (!fr.rst_n)
      (st.cfgd_en && st.sus) |-> !pin_out[1];
  endproperty
  a_cfg_low_sus: assert property (p_cfg_low_sus) else $error("config pin high in suspend");

  property p_resume;
    @(posedge ref_clk) disable iff (!fr.rst_n)
      (usb_resume || usb_bus_reset) |=> !suspended;
  endproperty
  a_resume: assert property (p_resume) else $error("suspend not left");

  property p_gp_out;
    @(posedge ref_clk) disable iff (!fr.rst_n)
      cfg_wr && !cfg_dir[2] |=> (pin_oe[2] && pin_out[2] == $past(cfg_default[2]));
  endproperty
  a_gp_out: assert property (p_gp_out) else $error("default level not driven");

  property p_in_dir;
    @(posedge ref_clk) disable iff (!fr.rst_n)
      cfg_wr && cfg_dir[3] |=> !pin_oe[3];
  endproperty
  a_in_dir: assert property (p_in_dir) else $error("input pin driven");

  property p_override;
    @(posedge ref_clk) disable iff (!fr.rst_n)
      st.cfgd_en |-> pin_oe[1];
  endproperty
  a_override: assert property (p_override) else $error("status pin not driven");

  property p_cfg_up;
    @(posedge ref_clk) disable iff (!fr.rst_n)
      (usb_configured && !usb_bus_reset && !st.sus && st.cfgd_en && !cfg_wr && !usb_suspend) |=> pin_out[1];
  endproperty
  a_cfg_up: assert property (p_cfg_up) else $error("config pin not high");

  property p_led_drive;
    @(posedge ref_clk) disable iff (!fr.rst_n)
      (st.in_mode != gpusb_pkg::gpusb_led_off) |-> ##1 (pin_oe[6] || $past(cfg_wr));
  endproperty
  a_led_drive: assert property (p_led_drive) else $error("traffic pin not driven");

  c_suspend: cover property (@(posedge ref_clk) disable iff (!fr.rst_n) st.sus_en && usb_suspend);
  c_configured: cover property (@(posedge ref_clk) disable iff (!fr.rst_n) st.cfgd_en && usb_configured);
  c_out_msg: cover property (@(posedge ref_clk) disable iff (!fr.rst_n) usb_out_msg && st.out_mode != 2'h0);

endmodule : gpusb_port

// file: testbench/gpusb_pins_model.sv
// Model of the application circuitry on the port pins
`timescale 1ns/10ps
module gpusb_pins_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] app_val,
  output logic [7:0] pin_lvl
);
  // ----------------------------------------------------------------
  // Wire level
  // ----------------------------------------------------------------
  // Device wins where it drives; the application drives the rest, so no pin floats
  assign pin_lvl = (pin_out & pin_oe) | (app_val & ~pin_oe);
endmodule : gpusb_pins_model

// file: testbench/gpusb_port_test.sv
// Self-checking bench for the port with suspend, configuration and traffic pins
`timescale 1ns/10ps
module gpusb_port_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int S = 20;
  localparam int L = 40;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic ext_rst_n = 1'b1;
  logic cfg_wr = 1'b0;
  logic gp_out_wr = 1'b0;
  logic sus_en = 1'b0;
  logic done_en = 1'b0;
  logic [7:0] dir = 8'hFF;
  logic [7:0] dflt = 8'h00;
  logic [7:0] gp_out = 8'h00;
  logic [7:0] app = 8'h00;
  logic [5:0] ev = 6'h00;
  gpusb_pkg::gpusb_led_mode_e in_mode = gpusb_pkg::gpusb_led_off;
  gpusb_pkg::gpusb_led_mode_e out_mode = gpusb_pkg::gpusb_led_off;
  logic [7:0] pin_in, pin_out, pin_oe, port_value;
  logic suspended, block_rst_n, lo;
  logic [31:0] seed = 32'h0001_0F12;
  logic [31:0] r;
  logic [7:0] lvl;
  logic [7:0] tbl [7] = '{8'hC8, 8'h01, 8'hC2, 8'h01, 8'hC3, 8'h01, 8'h44};
  int n;
  int mismatches = 0;
  int total_checks = 0;

  // Clock from the system side, 8 ns
  always #4 ref_clk = ~ref_clk;

  gpusb_port #(.SHORT_CYC(S), .LONG_CYC(L)) DUT (
    .ref_clk(ref_clk), .nrst(nrst), .ext_rst_n(ext_rst_n), .cfg_wr(cfg_wr),
    .cfg_dir(dir), .cfg_default(dflt), .cfg_suspend_en(sus_en), .cfg_done_en(done_en),
    .cfg_in_led_mode(in_mode), .cfg_out_led_mode(out_mode), .gp_out(gp_out), .gp_out_wr(gp_out_wr),
    .usb_suspend(ev[0]), .usb_resume(ev[1]), .usb_bus_reset(ev[2]), .usb_configured(ev[3]),
    .usb_in_msg(ev[4]), .usb_out_msg(ev[5]), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .port_value(port_value), .suspended(suspended), .block_rst_n(block_rst_n)
  );
  gpusb_pins_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .app_val(app), .pin_lvl(pin_in));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Level read back on each pin: own output where driven, application elsewhere
  function automatic logic [7:0] exp_port(input logic [7:0] d, input logic [7:0] f, input logic [7:0] a);
    return (f & ~d) | (a & d);
  endfunction : exp_port

  task chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask : chk

  task end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // Bounded wait so a stuck reset cannot hang the run
  task wait_rdy();
    int w;
    w = 0;
    while (block_rst_n !== 1'b1 && w < 100) begin
      @(negedge ref_clk);
      w++;
    end
    if (block_rst_n !== 1'b1) begin
      mismatches++;
      end_sim();
    end
  endtask : wait_rdy

  // Runtime write rides along to prove a same-cycle config wins
  task cfg(input logic [7:0] d, input logic [7:0] f, input logic s, input logic c,
           input gpusb_pkg::gpusb_led_mode_e im, input gpusb_pkg::gpusb_led_mode_e om);
    @(negedge ref_clk);
    dir = d;
    dflt = f;
    sus_en = s;
    done_en = c;
    in_mode = im;
    out_mode = om;
    gp_out = ~f;
    gp_out_wr = 1'b1;
    cfg_wr = 1'b1;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
    gp_out_wr = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask : cfg

  task pulse_ev(input logic [5:0] v);
    @(negedge ref_clk);
    ev = v;
    @(negedge ref_clk);
    ev = 6'h00;
  endtask : pulse_ev

  // Counts low samples of one pin; a pulse that never starts or never ends stops the run
  task meas(input int b, output int cnt);
    int w;
    w = 0;
    cnt = 0;
    while (pin_out[b] !== 1'b0 && w < 10) begin
      @(negedge ref_clk);
      w++;
    end
    while (pin_out[b] === 1'b0 && cnt < 200) begin
      @(negedge ref_clk);
      cnt++;
    end
    if (cnt == 0 || pin_out[b] === 1'b0) begin
      mismatches++;
      end_sim();
    end
  endtask : meas

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    wait_rdy();
    // Random directions, defaults, input levels and runtime writes
    for (int k = 0; k < 8; k++) begin
      r = xs();
      app = r[23:16];
      cfg(r[7:0], r[15:8], 1'b0, 1'b0, gpusb_pkg::gpusb_led_off, gpusb_pkg::gpusb_led_off);
      chk(pin_oe, ~r[7:0]);
      chk(pin_out & ~r[7:0], r[15:8] & ~r[7:0]);
      chk(port_value, exp_port(r[7:0], r[15:8], r[23:16]));
      @(negedge ref_clk);
      gp_out = r[31:24];
      gp_out_wr = 1'b1;
      @(negedge ref_clk);
      gp_out_wr = 1'b0;
      @(negedge ref_clk);
      chk(pin_out & ~r[7:0], r[31:24] & ~r[7:0]);
    end
    // Status pins over outputs driving high
    cfg(8'h00, 8'hFF, 1'b1, 1'b1, gpusb_pkg::gpusb_led_off, gpusb_pkg::gpusb_led_off);
    chk(pin_out & 8'h03, 8'h01);
    foreach (tbl[i]) begin
      pulse_ev(tbl[i][5:0]);
      repeat (3) @(negedge ref_clk);
      chk(pin_out & 8'h03, {6'h00, tbl[i][7:6]});
      chk({7'h00, suspended}, {7'h00, ~tbl[i][6]});
    end
    // Pulse indicators on input pins
    cfg(8'hFF, 8'h00, 1'b0, 1'b0, gpusb_pkg::gpusb_led_fast, gpusb_pkg::gpusb_led_slow);
    chk(pin_oe & 8'hC0, 8'hC0);
    chk(pin_out & 8'hC0, 8'hC0);
    pulse_ev(6'h10);
    meas(6, n);
    chk(n[7:0], 8'(S));
    pulse_ev(6'h20);
    meas(7, n);
    chk(n[7:0], 8'(L));
    pulse_ev(6'h10);
    repeat (5) @(negedge ref_clk);
    pulse_ev(6'h10);
    meas(6, n);
    chk(n[7:0], 8'(S + 1));
    // Toggle indicators, both streams at once
    cfg(8'hFF, 8'h00, 1'b0, 1'b0, gpusb_pkg::gpusb_led_toggle, gpusb_pkg::gpusb_led_toggle);
    lvl = 8'hC0;
    repeat (3) begin
      pulse_ev(6'h30);
      repeat (2) @(negedge ref_clk);
      lvl = lvl ^ 8'hC0;
      chk(pin_out & 8'hC0, lvl);
    end
    // Short glitch ignored, long low resets to all inputs
    ext_rst_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    ext_rst_n = 1'b1;
    lo = 1'b0;
    repeat (20) begin
      @(negedge ref_clk);
      lo = lo | ~block_rst_n;
    end
    chk({7'h00, lo}, 8'h00);
    ext_rst_n = 1'b0;
    repeat (30) @(negedge ref_clk);
    chk({7'h00, block_rst_n}, 8'h00);
    ext_rst_n = 1'b1;
    wait_rdy();
    chk(pin_oe, 8'h00);
    // Power-on reset in mid-run
    cfg(8'h00, 8'hA5, 1'b0, 1'b0, gpusb_pkg::gpusb_led_off, gpusb_pkg::gpusb_led_off);
    nrst = 1'b0;
    #1;
    chk(pin_oe, 8'h00);
    @(negedge ref_clk);
    nrst = 1'b1;
    wait_rdy();
    chk(pin_oe, 8'h00);
    end_sim();
  end
endmodule : gpusb_port_test
